// *** csr_core.sv ***
`timescale 1ns/1ps
module csr_core
	import csr_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire csr_stack_op_t stack_op_i,
	input wire logic [PC_W-1:0] pc_i,
	input wire logic irq_ext_req_i,
	input wire logic alu_go_i,
	input wire csr_alu_cmd_t alu_cmd_i,
	input wire logic sleep_entry_i,
	input wire logic dog_kick_i,
	input wire logic dog_timeout_i,
	input wire logic gie_set_i,
	input wire logic gie_clr_i,
	output logic [PC_W-1:0] pc_load_o,
	output logic pc_load_valid_o,
	output logic irq_ack_o,
	output logic irq_pending_o,
	output logic global_irq_enable_o,
	output logic [7:0] alu_result_o,
	output logic result_zero_o,
	output logic [7:0] work_register_o,
	output logic [7:0] flags_o,
	output logic stack_full_o
);
	localparam int GP_N = 64;

	logic [PC_W-1:0] stack_r [STACK_DEPTH];
	logic [PC_W-1:0] stack_nxt [STACK_DEPTH];
	logic [2:0] return_stack_pointer_r, return_stack_pointer_nxt;
	logic [7:0] gp_r [GP_N];
	logic [7:0] gp_nxt [GP_N];
	logic [6:0] indirect_pointer_r, indirect_pointer_nxt;
	logic [7:0] work_register_r, work_register_nxt;
	logic [7:0] flags_r, flags_nxt;
	logic global_irq_enable_r, global_irq_enable_nxt;
	logic irq_flag_r, irq_flag_nxt;
	logic [PC_W-1:0] pc_load_r, pc_load_nxt;
	logic pc_load_valid_r, pc_load_valid_nxt;
	logic irq_ack_r, irq_ack_nxt;
	logic [7:0] alu_result_r, alu_result_nxt;
	logic result_zero_r, result_zero_nxt;
	logic ext_s1_r, ext_s2_r;

	logic [6:0] eff_addr;
	logic eff_null;
	logic [7:0] rd_data, opa, opb, res;
	logic [8:0] sum9;
	logic [4:0] sum5;
	logic [7:0] sum7;
	logic full, take_irq, wr_en;
	logic [7:0] fl;

	// irq input arrives from a pin; two stages before use
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			ext_s1_r <= 1'b0;
			ext_s2_r <= 1'b0;
		end
		else
		begin
			ext_s1_r <= irq_ext_req_i;
			ext_s2_r <= ext_s1_r;
		end
	end

	always_comb
	begin
		eff_addr = alu_cmd_i.addr;
		eff_null = 1'b0;
		if (alu_cmd_i.addr == A_INDIRECT)
		begin
			eff_addr = indirect_pointer_r;
			eff_null = (indirect_pointer_r == A_INDIRECT);
		end
	end

	always_comb
	begin
		rd_data = 8'h00;
		if (eff_null)
			rd_data = 8'h00;
		else if (eff_addr >= A_GP_BASE)
			rd_data = gp_r[eff_addr[5:0]];
		else if (eff_addr == A_POINTER)
			rd_data = {1'b1, indirect_pointer_r} | PTR_READ_SET;
		else if (eff_addr == A_WORK)
			rd_data = work_register_r;
		else if (eff_addr == A_FLAGS)
			rd_data = {2'b00, flags_r[5:0]};
	end

	// ALU: operand a is work register, b is memory or immediate
	always_comb
	begin
		opa = work_register_r;
		opb = alu_cmd_i.use_imm ? alu_cmd_i.imm : rd_data;
		fl = flags_r;
		res = opb;
		sum9 = 9'h000;
		sum5 = 5'h00;
		sum7 = 8'h00;
		unique case (alu_cmd_i.op)
			CSR_ALU_ADD, CSR_ALU_ADC:
			begin
				sum9 = {1'b0, opa} + {1'b0, opb} + {8'h00,
					(alu_cmd_i.op == CSR_ALU_ADC) & flags_r[F_CARRY]};
				sum5 = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0,
					(alu_cmd_i.op == CSR_ALU_ADC) & flags_r[F_CARRY]};
				sum7 = {1'b0, opa[6:0]} + {1'b0, opb[6:0]} + {7'h00,
					(alu_cmd_i.op == CSR_ALU_ADC) & flags_r[F_CARRY]};
				res = sum9[7:0];
				fl[F_CARRY] = sum9[8];
				fl[F_NIBBLE] = sum5[4];
				fl[F_WRAP] = sum7[7] ^ sum9[8];
			end
			CSR_ALU_SUB, CSR_ALU_SBC:
			begin
				// subtract as add of complement: carry means no borrow
				sum9 = {1'b0, opb} + {1'b0, ~opa} + {8'h00,
					(alu_cmd_i.op == CSR_ALU_SUB) | flags_r[F_CARRY]};
				sum5 = {1'b0, opb[3:0]} + {1'b0, ~opa[3:0]} + {4'h0,
					(alu_cmd_i.op == CSR_ALU_SUB) | flags_r[F_CARRY]};
				sum7 = {1'b0, opb[6:0]} + {1'b0, ~opa[6:0]} + {7'h00,
					(alu_cmd_i.op == CSR_ALU_SUB) | flags_r[F_CARRY]};
				res = sum9[7:0];
				fl[F_CARRY] = sum9[8];
				fl[F_NIBBLE] = sum5[4];
				fl[F_WRAP] = sum7[7] ^ sum9[8];
			end
			CSR_ALU_DAA:
			begin
				sum9 = {1'b0, opa};
				if (opa[3:0] > 4'h9 || flags_r[F_NIBBLE])
					sum9 = sum9 + 9'h006;
				if (sum9[7:4] > 4'h9 || flags_r[F_CARRY] || sum9[8])
					sum9 = sum9 + 9'h060;
				res = sum9[7:0];
				fl[F_CARRY] = sum9[8] | flags_r[F_CARRY];
			end
			CSR_ALU_AND: res = opa & opb;
			CSR_ALU_OR: res = opa | opb;
			CSR_ALU_XOR: res = opa ^ opb;
			CSR_ALU_CPL: res = ~opb;
			CSR_ALU_RL: res = {opb[6:0], opb[7]};
			CSR_ALU_RR: res = {opb[0], opb[7:1]};
			CSR_ALU_RLC:
			begin
				res = {opb[6:0], flags_r[F_CARRY]};
				fl[F_CARRY] = opb[7];
			end
			CSR_ALU_RRC:
			begin
				res = {flags_r[F_CARRY], opb[7:1]};
				fl[F_CARRY] = opb[0];
			end
			CSR_ALU_INC: res = opb + 8'h01;
			CSR_ALU_DEC: res = opb - 8'h01;
			CSR_ALU_MOV: res = opb;
			CSR_ALU_NOP: res = opb;
		endcase
		// rotates and moves leave the zero flag alone
		if (alu_cmd_i.op inside {CSR_ALU_ADD, CSR_ALU_ADC, CSR_ALU_SUB,
			CSR_ALU_SBC, CSR_ALU_DAA, CSR_ALU_AND, CSR_ALU_OR, CSR_ALU_XOR,
			CSR_ALU_CPL, CSR_ALU_INC, CSR_ALU_DEC})
			fl[F_ZERO] = (res == 8'h00);
	end

	assign full = (return_stack_pointer_r == 3'(STACK_DEPTH));
	assign take_irq = global_irq_enable_r && (irq_flag_r || ext_s2_r)
		&& !full && stack_op_i == CSR_STK_NONE;

	always_comb
	begin
		stack_nxt = stack_r;
		return_stack_pointer_nxt = return_stack_pointer_r;
		pc_load_nxt = pc_load_r;
		pc_load_valid_nxt = 1'b0;
		irq_ack_nxt = 1'b0;
		global_irq_enable_nxt = global_irq_enable_r;
		irq_flag_nxt = irq_flag_r;
		if (gie_set_i)
			global_irq_enable_nxt = 1'b1;
		if (gie_clr_i)
			global_irq_enable_nxt = 1'b0;
		unique case (stack_op_i)
			CSR_STK_CALL:
			begin
				if (full)
				begin
					// drop the oldest entry, shift the rest down
					for (int i = 0; i < STACK_DEPTH - 1; i++)
						stack_nxt[i] = stack_r[i+1];
					stack_nxt[STACK_DEPTH-1] = pc_i;
				end
				else
				begin
					stack_nxt[return_stack_pointer_r] = pc_i;
					return_stack_pointer_nxt = return_stack_pointer_r + 3'd1;
				end
			end
			CSR_STK_RET, CSR_STK_IRQ_EXIT:
			begin
				if (return_stack_pointer_r != 3'd0)
				begin
					pc_load_nxt = stack_r[return_stack_pointer_r - 3'd1];
					return_stack_pointer_nxt = return_stack_pointer_r - 3'd1;
				end
				pc_load_valid_nxt = 1'b1;
				if (stack_op_i == CSR_STK_IRQ_EXIT)
					global_irq_enable_nxt = 1'b1;
			end
			CSR_STK_NONE:
			begin
				if (take_irq)
				begin
					stack_nxt[return_stack_pointer_r] = pc_i;
					return_stack_pointer_nxt = return_stack_pointer_r + 3'd1;
					pc_load_nxt = IRQ_EXT_VECTOR;
					pc_load_valid_nxt = 1'b1;
					irq_ack_nxt = 1'b1;
					global_irq_enable_nxt = 1'b0;
				end
			end
		endcase
		// service clears the flag; a level still high re-latches it next cycle
		if (take_irq)
			irq_flag_nxt = 1'b0;
		if (ext_s2_r && !take_irq)
			irq_flag_nxt = 1'b1;
	end

	always_comb
	begin
		gp_nxt = gp_r;
		indirect_pointer_nxt = indirect_pointer_r;
		work_register_nxt = work_register_r;
		flags_nxt = flags_r;
		alu_result_nxt = alu_result_r;
		result_zero_nxt = result_zero_r;
		wr_en = alu_go_i && alu_cmd_i.to_mem && !eff_null;
		if (alu_go_i)
		begin
			flags_nxt[3:0] = fl[3:0];
			alu_result_nxt = res;
			result_zero_nxt = (res == 8'h00);
			if (alu_cmd_i.to_work)
				work_register_nxt = res;
			if (wr_en)
			begin
				if (eff_addr >= A_GP_BASE)
					gp_nxt[eff_addr[5:0]] = res;
				else if (eff_addr == A_POINTER)
					indirect_pointer_nxt = res[6:0];
				else if (eff_addr == A_WORK)
					work_register_nxt = res;
				else if (eff_addr == A_FLAGS)
					flags_nxt[3:0] = res[3:0] & FLAGS_SW_MASK[3:0];
			end
		end
		// no status save on call or irq entry
		if (dog_kick_i || sleep_entry_i)
			flags_nxt[F_DOG] = 1'b0;
		if (dog_timeout_i)
			flags_nxt[F_DOG] = 1'b1;
		if (dog_kick_i)
			flags_nxt[F_HALT] = 1'b0;
		if (sleep_entry_i)
			flags_nxt[F_HALT] = 1'b1;
		flags_nxt[7:6] = 2'b00;
	end

	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			for (int i = 0; i < STACK_DEPTH; i++)
				stack_r[i] <= '0;
			for (int i = 0; i < GP_N; i++)
				gp_r[i] <= 8'h00;
			return_stack_pointer_r <= 3'd0;
			indirect_pointer_r <= 7'h00;
			work_register_r <= 8'h00;
			flags_r <= 8'h00;
			global_irq_enable_r <= 1'b0;
			irq_flag_r <= 1'b0;
			pc_load_r <= '0;
			pc_load_valid_r <= 1'b0;
			irq_ack_r <= 1'b0;
			alu_result_r <= 8'h00;
			result_zero_r <= 1'b0;
		end
		else
		begin
			stack_r <= stack_nxt;
			gp_r <= gp_nxt;
			return_stack_pointer_r <= return_stack_pointer_nxt;
			indirect_pointer_r <= indirect_pointer_nxt;
			work_register_r <= work_register_nxt;
			flags_r <= flags_nxt;
			global_irq_enable_r <= global_irq_enable_nxt;
			irq_flag_r <= irq_flag_nxt;
			pc_load_r <= pc_load_nxt;
			pc_load_valid_r <= pc_load_valid_nxt;
			irq_ack_r <= irq_ack_nxt;
			alu_result_r <= alu_result_nxt;
			result_zero_r <= result_zero_nxt;
		end
	end

	logic stack_full_r, irq_pending_r;
	always_ff @(posedge clk_sys_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			stack_full_r <= 1'b0;
			irq_pending_r <= 1'b0;
		end
		else
		begin
			stack_full_r <= (return_stack_pointer_nxt == 3'(STACK_DEPTH));
			irq_pending_r <= irq_flag_nxt;
		end
	end

	assign pc_load_o = pc_load_r;
	assign pc_load_valid_o = pc_load_valid_r;
	assign irq_ack_o = irq_ack_r;
	assign irq_pending_o = irq_pending_r;
	assign global_irq_enable_o = global_irq_enable_r;
	assign alu_result_o = alu_result_r;
	assign result_zero_o = result_zero_r;
	assign work_register_o = work_register_r;
	assign flags_o = flags_r;
	assign stack_full_o = stack_full_r;
endmodule : csr_core

// *** csr_core_asserts.sv ***
`timescale 1ns/1ps
module csr_core_asserts
	import csr_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic reset_n_i,
	input wire csr_stack_op_t stack_op_i,
	input wire logic gie_clr_i,
	input wire logic sleep_entry_i,
	input wire logic dog_kick_i,
	input wire logic dog_timeout_i,
	input wire logic [PC_W-1:0] pc_load_o,
	input wire logic pc_load_valid_o,
	input wire logic irq_ack_o,
	input wire logic global_irq_enable_o,
	input wire logic [7:0] flags_o,
	input wire logic stack_full_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);
	flags_top_a: assert property (flags_o[7:6] == 2'b00)
		else $error("status top bits set");
	ack_full_a: assert property (irq_ack_o |-> !$past(stack_full_o))
		else $error("ack with full stack");
	ack_gie_a: assert property (irq_ack_o |-> !global_irq_enable_o &&
		$past(global_irq_enable_o))
		else $error("ack enable wrong");
	ack_vector_a: assert property (irq_ack_o |-> pc_load_valid_o &&
		pc_load_o == IRQ_EXT_VECTOR && $past(stack_op_i) == CSR_STK_NONE)
		else $error("ack vector wrong");
	irq_exit_gie_a: assert property (stack_op_i == CSR_STK_IRQ_EXIT &&
		!gie_clr_i |=> global_irq_enable_o)
		else $error("irq exit left enable low");
	pop_pulse_a: assert property (stack_op_i inside {CSR_STK_RET,
		CSR_STK_IRQ_EXIT} |=> pc_load_valid_o && !irq_ack_o ##1
		(!pc_load_valid_o || irq_ack_o ||
		$past(stack_op_i) != CSR_STK_NONE))
		else $error("pop pulse wrong");
	sleep_flag_a: assert property (sleep_entry_i && !dog_kick_i &&
		!dog_timeout_i |=> flags_o[F_HALT] && !flags_o[F_DOG])
		else $error("sleep flags wrong");
	kick_flag_a: assert property (dog_kick_i && !sleep_entry_i &&
		!dog_timeout_i |=> flags_o[5:4] == 2'b00)
		else $error("kick flags wrong");
	full_call_a: assert property (stack_full_o &&
		stack_op_i == CSR_STK_CALL |=> stack_full_o)
		else $error("full stack lost");
endmodule : csr_core_asserts
bind csr_core csr_core_asserts u_chk (.clk_sys_i, .reset_n_i, .stack_op_i,
	.gie_clr_i, .sleep_entry_i, .dog_kick_i, .dog_timeout_i, .pc_load_o,
	.pc_load_valid_o, .irq_ack_o, .global_irq_enable_o, .flags_o,
	.stack_full_o);

// *** csr_pkg.sv ***
package csr_pkg;
	localparam int PC_W = 11;
	localparam int STACK_DEPTH = 6;
	localparam logic [6:0] A_INDIRECT = 7'h00;
	localparam logic [6:0] A_POINTER = 7'h01;
	localparam logic [6:0] A_WORK = 7'h05;
	localparam logic [6:0] A_FLAGS = 7'h0a;
	localparam logic [6:0] A_GP_BASE = 7'h40;
	localparam logic [10:0] IRQ_EXT_VECTOR = 11'h004;
	localparam int F_CARRY = 0;
	localparam int F_NIBBLE = 1;
	localparam int F_ZERO = 2;
	localparam int F_WRAP = 3;
	localparam int F_HALT = 4;
	localparam int F_DOG = 5;
	localparam logic [7:0] FLAGS_SW_MASK = 8'h0f;
	localparam logic [7:0] PTR_READ_SET = 8'h80;

	typedef enum logic [1:0] {CSR_STK_NONE, CSR_STK_CALL, CSR_STK_RET,
		CSR_STK_IRQ_EXIT} csr_stack_op_t;

	typedef enum logic [4:0] {CSR_ALU_NOP, CSR_ALU_ADD, CSR_ALU_ADC,
		CSR_ALU_SUB, CSR_ALU_SBC, CSR_ALU_DAA, CSR_ALU_AND, CSR_ALU_OR,
		CSR_ALU_XOR, CSR_ALU_CPL, CSR_ALU_RL, CSR_ALU_RR, CSR_ALU_RLC,
		CSR_ALU_RRC, CSR_ALU_INC, CSR_ALU_DEC, CSR_ALU_MOV} csr_alu_op_t;

	typedef struct packed {
		csr_alu_op_t op;
		logic [6:0] addr;
		logic [7:0] imm;
		logic use_imm;
		logic to_work;
		logic to_mem;
	} csr_alu_cmd_t;
endpackage : csr_pkg

// *** test_csr_core.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) checks++; if ((g) !== (e)) begin miscompares++; \
	$display("wrong value %s exp %h got %h", n, e, g); end
module test_csr_core;
	import csr_pkg::*;
	logic clk_sys_i, reset_n_i, irq_ext_req_i, alu_go_i;
	logic sleep_entry_i, dog_kick_i, dog_timeout_i, gie_set_i, gie_clr_i;
	csr_stack_op_t stack_op_i;
	logic [PC_W-1:0] pc_i, pc_load_o;
	csr_alu_cmd_t alu_cmd_i;
	logic pc_load_valid_o, irq_ack_o, irq_pending_o, global_irq_enable_o;
	logic result_zero_o, stack_full_o;
	logic [7:0] alu_result_o, work_register_o, flags_o;
	int miscompares, checks, cycles, acks, i;
	csr_core dut (.clk_sys_i, .reset_n_i, .stack_op_i, .pc_i, .irq_ext_req_i,
		.alu_go_i, .alu_cmd_i, .sleep_entry_i, .dog_kick_i, .dog_timeout_i,
		.gie_set_i, .gie_clr_i, .pc_load_o, .pc_load_valid_o, .irq_ack_o,
		.irq_pending_o, .global_irq_enable_o, .alu_result_o, .result_zero_o,
		.work_register_o, .flags_o, .stack_full_o);
	initial
	begin
		clk_sys_i = 0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	task test_done;
		if (miscompares == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done
	always @(posedge clk_sys_i)
	begin
		cycles++;
		if (irq_ack_o === 1'b1)
			acks++;
		if (cycles == 3000)
		begin
			miscompares++;
			test_done;
		end
	end
	task alu(input csr_alu_op_t op, input logic [6:0] a, input logic [7:0] v,
		input logic imm, input logic w, input logic m);
		@(posedge clk_sys_i);
		alu_go_i <= 1;
		alu_cmd_i <= '{op, a, v, imm, w, m};
		@(posedge clk_sys_i);
		alu_go_i <= 0;
		#1;
	endtask : alu
	task rd(input logic [6:0] a, input logic [7:0] e);
		alu(CSR_ALU_MOV, a, 8'h00, 0, 0, 0);
		`CHK("read", e, alu_result_o)
	endtask : rd
	task ev(input logic [3:0] v);
		@(posedge clk_sys_i);
		{gie_set_i, sleep_entry_i, dog_kick_i, dog_timeout_i} <= v;
		@(posedge clk_sys_i);
		{gie_set_i, sleep_entry_i, dog_kick_i, dog_timeout_i} <= 4'h0;
		#1;
	endtask : ev
	task stk(input csr_stack_op_t op, input logic [PC_W-1:0] pc);
		@(posedge clk_sys_i);
		stack_op_i <= op;
		pc_i <= pc;
		@(posedge clk_sys_i);
		stack_op_i <= CSR_STK_NONE;
		#1;
	endtask : stk
	task flg(input csr_alu_op_t op, input logic [7:0] w, input logic [7:0] v,
		input logic [7:0] r, input logic [7:0] f);
		alu(CSR_ALU_MOV, 7'h00, w, 1, 1, 0);
		alu(op, 7'h00, v, 1, 1, 0);
		`CHK("result", r, alu_result_o)
		`CHK("flags", f, flags_o)
	endtask : flg
	initial
	begin
		{reset_n_i, irq_ext_req_i, alu_go_i, gie_clr_i} = 4'h0;
		{gie_set_i, sleep_entry_i, dog_kick_i, dog_timeout_i} = 4'h0;
		stack_op_i = CSR_STK_NONE;
		pc_i = '0;
		alu_cmd_i = '0;
		repeat (5) @(posedge clk_sys_i);
		reset_n_i <= 1;
		#1;
		`CHK("full", 1'b0, stack_full_o)
		`CHK("flags", 8'h00, flags_o)
		alu(CSR_ALU_MOV, 7'h40, 8'ha5, 1, 0, 1);
		alu(CSR_ALU_MOV, 7'h7f, 8'h3c, 1, 0, 1);
		rd(7'h40, 8'ha5);
		rd(7'h7f, 8'h3c);
		rd(7'h30, 8'h00);
		alu(CSR_ALU_MOV, A_POINTER, 8'hc5, 1, 0, 1);
		rd(A_POINTER, 8'hc5);
		alu(CSR_ALU_MOV, A_INDIRECT, 8'h5a, 1, 0, 1);
		rd(7'h45, 8'h5a);
		alu(CSR_ALU_MOV, A_POINTER, 8'h80, 1, 0, 1);
		rd(A_INDIRECT, 8'h00);
		flg(CSR_ALU_ADD, 8'h80, 8'h80, 8'h00, 8'h0d);
		`CHK("zero", 1'b1, result_zero_o)
		flg(CSR_ALU_ADD, 8'h08, 8'h08, 8'h10, 8'h02);
		`CHK("work", 8'h10, work_register_o)
		flg(CSR_ALU_SUB, 8'h03, 8'h05, 8'h02, 8'h03);
		flg(CSR_ALU_SUB, 8'h05, 8'h03, 8'hfe, 8'h00);
		flg(CSR_ALU_ADC, 8'hff, 8'h01, 8'h00, 8'h07);
		flg(CSR_ALU_ADC, 8'h10, 8'h20, 8'h31, 8'h00);
		flg(CSR_ALU_SBC, 8'h02, 8'h05, 8'h02, 8'h03);
		flg(CSR_ALU_DAA, 8'h9a, 8'h00, 8'h00, 8'h07);
		flg(CSR_ALU_AND, 8'hf0, 8'h3c, 8'h30, 8'h03);
		flg(CSR_ALU_OR, 8'h0f, 8'hf0, 8'hff, 8'h03);
		flg(CSR_ALU_XOR, 8'h5a, 8'h5a, 8'h00, 8'h07);
		flg(CSR_ALU_CPL, 8'h00, 8'h0f, 8'hf0, 8'h03);
		flg(CSR_ALU_RL, 8'h00, 8'h81, 8'h03, 8'h03);
		flg(CSR_ALU_RR, 8'h00, 8'h81, 8'hc0, 8'h03);
		flg(CSR_ALU_RLC, 8'h00, 8'h01, 8'h03, 8'h02);
		flg(CSR_ALU_RRC, 8'h00, 8'h01, 8'h00, 8'h03);
		flg(CSR_ALU_INC, 8'h00, 8'hff, 8'h00, 8'h07);
		flg(CSR_ALU_DEC, 8'h00, 8'h00, 8'hff, 8'h03);
		alu(CSR_ALU_MOV, A_FLAGS, 8'hff, 1, 0, 1);
		`CHK("flags", 8'h0f, flags_o)
		ev(4'h4);
		`CHK("flags", 8'h1f, flags_o)
		ev(4'h1);
		`CHK("flags", 8'h3f, flags_o)
		alu(CSR_ALU_MOV, A_FLAGS, 8'h00, 1, 0, 1);
		`CHK("flags", 8'h30, flags_o)
		ev(4'h4);
		`CHK("flags", 8'h10, flags_o)
		ev(4'h2);
		`CHK("flags", 8'h00, flags_o)
		for (i = 1; i <= 7; i++)
			stk(CSR_STK_CALL, 11'(i));
		`CHK("full", 1'b1, stack_full_o)
		ev(4'h8);
		@(posedge clk_sys_i);
		irq_ext_req_i <= 1;
		repeat (6) @(posedge clk_sys_i);
		#1;
		`CHK("pending", 1'b1, irq_pending_o)
		`CHK("acks", 0, acks)
		@(posedge clk_sys_i);
		irq_ext_req_i <= 0;
		stk(CSR_STK_RET, 11'h0aa);
		`CHK("pop", 11'h007, pc_load_o)
		`CHK("valid", 1'b1, pc_load_valid_o)
		for (i = 0; i < 8 && irq_ack_o !== 1'b1; i++)
			@(posedge clk_sys_i) #1;
		`CHK("ack", 1'b1, irq_ack_o)
		`CHK("vector", IRQ_EXT_VECTOR, pc_load_o)
		`CHK("gie", 1'b0, global_irq_enable_o)
		`CHK("full", 1'b1, stack_full_o)
		stk(CSR_STK_IRQ_EXIT, 11'h000);
		`CHK("pop", 11'h0aa, pc_load_o)
		`CHK("gie", 1'b1, global_irq_enable_o)
		for (i = 6; i >= 2; i--)
		begin
			stk(CSR_STK_RET, 11'h000);
			`CHK("pop", 11'(i), pc_load_o)
		end
		`CHK("gie", 1'b1, global_irq_enable_o)
		`CHK("full", 1'b0, stack_full_o)
		@(posedge clk_sys_i);
		gie_clr_i <= 1;
		@(posedge clk_sys_i);
		gie_clr_i <= 0;
		irq_ext_req_i <= 1;
		repeat (6) @(posedge clk_sys_i);
		#1;
		`CHK("gie", 1'b0, global_irq_enable_o)
		`CHK("pending", 1'b1, irq_pending_o)
		`CHK("acks", 1, acks)
		test_done;
	end
endmodule : test_csr_core
